// ---- spg_top.sv ----
// Page select register and password write guard on the SFR access port
`timescale 1ns/10ps
module spg_top
	import spg_pkg::*;
#(
	parameter logic [7:0] ADDR_PAGE = SPG_ADDR_PAGE,
	parameter logic [7:0] ADDR_KEY = SPG_ADDR_KEY,
	parameter logic [7:0] ADDR_SYSCTL = SPG_ADDR_SYSCTL
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// SFR access port from the core
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Active module page
	output logic [2:0] page_sel,
	// Guard state
	output logic protect_status,
	output logic [1:0] guard_mode,
	// Guarded system controls
	output logic [3:0] pll_divider_factor,
	output logic watchdog_enable_bit,
	output logic power_down_ctrl,
	output logic slowdown_ctrl
);
	localparam logic [5:0] WINDOW_LAST = 6'(SPG_WINDOW_CYC - 1);

	// Elaboration checks on the configuration
	if (ADDR_PAGE == ADDR_KEY)
	begin : g_bad_page_key
		$error("spg_top: page and key registers share an address");
	end
	if (ADDR_PAGE == ADDR_SYSCTL)
	begin : g_bad_page_sys
		$error("spg_top: page and system control registers share an address");
	end
	if (ADDR_KEY == ADDR_SYSCTL)
	begin : g_bad_key_sys
		$error("spg_top: key and system control registers share an address");
	end
	// The countdown register holds at most 64 cycles
	if (SPG_WINDOW_CYC < 1 || SPG_WINDOW_CYC > 64)
	begin : g_bad_window
		$error("spg_top: unlock window does not fit the countdown");
	end
	if (SPG_KEY_MODE == SPG_KEY_OPEN || SPG_KEY_MODE == SPG_KEY_CLOSE
		|| SPG_KEY_OPEN == SPG_KEY_CLOSE)
	begin : g_bad_keys
		$error("spg_top: key patterns must differ");
	end
	// Guarded control fields must not overlap
	if (SPG_DIV_LSB + SPG_DIV_W > SPG_WDT_BIT || SPG_SLOW_BIT > 7)
	begin : g_bad_ctl
		$error("spg_top: guarded control fields overlap");
	end
	// Status bit sits between the mode and key fields
	if (SPG_STATUS_BIT != SPG_MODE_LSB + 2 || SPG_KEY_LSB != SPG_STATUS_BIT + 1)
	begin : g_bad_key_layout
		$error("spg_top: key register layout does not fit");
	end

	// Address decode
	logic wr_page, wr_key, wr_sys;
	always_comb
	begin
		wr_page = 1'b0;
		wr_key = 1'b0;
		wr_sys = 1'b0;
		if (!sfr_wr)
		begin
			wr_page = 1'b0;
		end
		else if (sfr_addr == ADDR_PAGE)
		begin
			wr_page = 1'b1;
		end
		else if (sfr_addr == ADDR_KEY)
		begin
			wr_key = 1'b1;
		end
		else if (sfr_addr == ADDR_SYSCTL)
		begin
			wr_sys = 1'b1;
		end
	end

	// Read decode; unmapped addresses read as zero
	logic rd_page, rd_key, rd_sys, rd_none;
	always_comb
	begin
		rd_page = 1'b0;
		rd_key = 1'b0;
		rd_sys = 1'b0;
		rd_none = 1'b0;
		if (!sfr_rd)
		begin
			rd_none = 1'b0;
		end
		else if (sfr_addr == ADDR_PAGE)
		begin
			rd_page = 1'b1;
		end
		else if (sfr_addr == ADDR_KEY)
		begin
			rd_key = 1'b1;
		end
		else if (sfr_addr == ADDR_SYSCTL)
		begin
			rd_sys = 1'b1;
		end
		else
		begin
			rd_none = 1'b1;
		end
	end

	// Page register
	logic [7:0] page_rd;
	logic [2:0] page_now;

	spg_page_reg #(
		.PAGE_W(3),
		.SLOTS(4)
	) spg_page_reg_inst (
		.mclk(mclk),
		.nrst(nrst),
		.wr_en(wr_page),
		.wdata(sfr_wdata),
		.rd_value(page_rd),
		.page_active(page_now)
	);

	// Write guard state
	logic [1:0] mode_q, mode_d;
	logic open_q, open_d;
	logic [5:0] cnt_q, cnt_d;
	logic [4:0] key;
	logic writable;
	logic key_mode, key_open, key_close;

	assign key = sfr_wdata[SPG_KEY_LSB +: 5];

	// Key pattern decode; any other pattern has no effect
	always_comb
	begin
		key_mode = 1'b0;
		key_open = 1'b0;
		key_close = 1'b0;
		if (!wr_key)
		begin
			key_mode = 1'b0;
		end
		else if (key == SPG_KEY_MODE)
		begin
			key_mode = 1'b1;
		end
		else if (key == SPG_KEY_OPEN)
		begin
			key_open = 1'b1;
		end
		else if (key == SPG_KEY_CLOSE)
		begin
			key_close = 1'b1;
		end
	end

	always_comb
	begin
		mode_d = mode_q;
		open_d = open_q;
		cnt_d = cnt_q;
		// Countdown of the unlock window
		if (open_q)
		begin
			if (cnt_q == 6'h00)
				open_d = 1'b0;
			else
				cnt_d = cnt_q - 6'h01;
		end
		// Unknown patterns fall through untouched
		if (key_mode)
		begin
			mode_d = sfr_wdata[SPG_MODE_LSB +: 2];
		end
		else if (key_open && mode_q == SPG_MODE_FULL)
		begin
			open_d = 1'b1;
			cnt_d = WINDOW_LAST;
		end
		else if (key_close)
		begin
			open_d = 1'b0;
			cnt_d = 6'h00;
		end
	end

	// Guard state registers
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_q <= SPG_MODE_RESET;
			open_q <= 1'b0;
			cnt_q <= 6'h00;
		end
		else
		begin
			mode_q <= mode_d;
			open_q <= open_d;
			cnt_q <= cnt_d;
		end
	end

	// Protection off in mode 00, otherwise only while open
	assign writable = (mode_q == SPG_MODE_OFF) || open_q;

	// Guarded system control register
	logic [7:0] sys_q, sys_d;
	always_comb
	begin
		sys_d = sys_q;
		if (wr_sys && writable)
		begin
			sys_d[SPG_DIV_LSB +: SPG_DIV_W] = sfr_wdata[SPG_DIV_LSB +: SPG_DIV_W];
			sys_d[SPG_WDT_BIT] = sfr_wdata[SPG_WDT_BIT];
			sys_d[SPG_PWRDN_BIT] = sfr_wdata[SPG_PWRDN_BIT];
			sys_d[SPG_SLOW_BIT] = sfr_wdata[SPG_SLOW_BIT];
		end
	end

	// Guarded control registers
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sys_q <= SPG_SYSCTL_RESET;
		end
		else
		begin
			sys_q <= sys_d;
		end
	end

	// Read mux and registered outputs
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] key_rd;
	logic status_d;

	// Status reflects the guard state after this edge
	always_comb
	begin
		status_d = !((mode_d == SPG_MODE_OFF) || open_d);
		key_rd = 8'h00;
		key_rd[SPG_STATUS_BIT] = !writable;
		key_rd[SPG_MODE_LSB +: 2] = mode_q;
		rdata_d = rdata_q;
		if (rd_page)
			rdata_d = page_rd;
		else if (rd_key)
			rdata_d = key_rd;
		else if (rd_sys)
			rdata_d = sys_q;
		else if (rd_none)
			rdata_d = 8'h00;
	end

	// Read data holds until the next read
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_q <= 8'h00;
			protect_status <= SPG_KEY_RESET[SPG_STATUS_BIT];
		end
		else
		begin
			rdata_q <= rdata_d;
			protect_status <= status_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign page_sel = page_now;
	assign guard_mode = mode_q;
	assign pll_divider_factor = sys_q[SPG_DIV_LSB +: SPG_DIV_W];
	assign watchdog_enable_bit = sys_q[SPG_WDT_BIT];
	assign power_down_ctrl = sys_q[SPG_PWRDN_BIT];
	assign slowdown_ctrl = sys_q[SPG_SLOW_BIT];
endmodule // spg_top

// ---- spg_pkg.sv ----
// Constants shared by the page select and write guard logic
package spg_pkg;
	// SFR addresses (arbitrary defaults, overridable at the top)
	localparam logic [7:0] SPG_ADDR_PAGE = 8'hA1;
	localparam logic [7:0] SPG_ADDR_KEY = 8'hBB;
	localparam logic [7:0] SPG_ADDR_SYSCTL = 8'hBC;
	// Page register layout
	localparam int SPG_PAGE_LSB = 0;
	localparam int SPG_RSVD_BIT = 3;
	localparam int SPG_SLOT_LSB = 4;
	localparam int SPG_ACTION_LSB = 6;
	localparam logic [7:0] SPG_PAGE_RESET = 8'h00;
	// Key register layout
	localparam int SPG_MODE_LSB = 0;
	localparam int SPG_STATUS_BIT = 2;
	localparam int SPG_KEY_LSB = 3;
	localparam logic [7:0] SPG_KEY_RESET = 8'h07;
	localparam logic [1:0] SPG_MODE_RESET = 2'h3;
	localparam logic [1:0] SPG_MODE_OFF = 2'h0;
	localparam logic [1:0] SPG_MODE_FULL = 2'h3;
	// Key patterns
	localparam logic [4:0] SPG_KEY_MODE = 5'h18;
	localparam logic [4:0] SPG_KEY_OPEN = 5'h13;
	localparam logic [4:0] SPG_KEY_CLOSE = 5'h15;
	// Unlock window in core clock cycles
	localparam int SPG_WINDOW_CYC = 32;
	// Guarded system control register layout
	localparam int SPG_DIV_LSB = 0;
	localparam int SPG_DIV_W = 4;
	localparam int SPG_WDT_BIT = 4;
	localparam int SPG_PWRDN_BIT = 5;
	localparam int SPG_SLOW_BIT = 6;
	localparam logic [7:0] SPG_SYSCTL_RESET = 8'h00;
	// Page action codes
	typedef enum logic [1:0]
	{
		SPG_ACT_MAN0 = 2'b00,
		SPG_ACT_MAN1 = 2'b01,
		SPG_ACT_SAVE = 2'b10,
		SPG_ACT_REST = 2'b11
	} spg_action_t;
endpackage

// ---- spg_page_reg.sv ----
// Module page register with save slots
`timescale 1ns/10ps
module spg_page_reg
	import spg_pkg::*;
#(
	parameter int PAGE_W = 3,
	parameter int SLOTS = 4
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// State
	output logic [7:0] rd_value,
	output logic [PAGE_W-1:0] page_active
);
	// Elaboration check on the configuration
	if (PAGE_W != 3 || SLOTS != 4)
	begin : g_bad_size
		$error("spg_page_reg: only 3-bit page and 4 slots supported");
	end

	logic [PAGE_W-1:0] page_q, page_d;
	logic [PAGE_W-1:0] slot_q [SLOTS];
	logic [PAGE_W-1:0] slot_d [SLOTS];
	spg_action_t action;
	logic [1:0] slot_idx;
	logic [PAGE_W-1:0] new_page;

	assign action = spg_action_t'(wdata[SPG_ACTION_LSB +: 2]);
	assign slot_idx = wdata[SPG_SLOT_LSB +: 2];
	assign new_page = wdata[SPG_PAGE_LSB +: PAGE_W];

	always_comb
	begin
		page_d = page_q;
		for (int i = 0; i < SLOTS; i++)
			slot_d[i] = slot_q[i];
		if (wr_en)
		begin
			case (action)
				SPG_ACT_SAVE:
				begin
					page_d = new_page;
					slot_d[slot_idx] = page_q;
				end
				SPG_ACT_REST:
					page_d = slot_q[slot_idx];
				default:
					page_d = new_page;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			page_q <= SPG_PAGE_RESET[PAGE_W-1:0];
			for (int i = 0; i < SLOTS; i++)
				slot_q[i] <= '0;
		end
		else
		begin
			page_q <= page_d;
			for (int i = 0; i < SLOTS; i++)
				slot_q[i] <= slot_d[i];
		end
	end

	// Write-only fields and reserved bit read as zero
	assign rd_value = {5'h00, page_q};
	assign page_active = page_q;
endmodule // spg_page_reg

// ---- spg_properties.sv ----
// Port checker for page select and write guard
`timescale 1ns/10ps
module spg_properties
	import spg_pkg::*;
(
	// Clock and reset
	input logic mclk,
	input logic nrst,
	// Register access port
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	// Block outputs
	input logic [7:0] sfr_rdata,
	input logic [2:0] page_sel,
	input logic protect_status,
	input logic [1:0] guard_mode,
	input logic [3:0] pll_divider_factor,
	input logic watchdog_enable_bit,
	input logic power_down_ctrl,
	input logic slowdown_ctrl
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire kw = sfr_wr && sfr_addr == SPG_ADDR_KEY;
	wire [4:0] k = sfr_wdata[7:3];
	wire cw = sfr_wr && sfr_addr == SPG_ADDR_SYSCTL && !protect_status;
	wire [6:0] ctl = {slowdown_ctrl, power_down_ctrl, watchdog_enable_bit, pll_divider_factor};
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	// Unlocked cycles since the last open key
	always_comb
		cnt_d = (kw && k == SPG_KEY_OPEN || protect_status) ? 6'h00 : cnt_q + 6'h01;
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			cnt_q <= 6'h00;
		else
			cnt_q <= cnt_d;
	sequence open_s;
		kw && k == SPG_KEY_OPEN && guard_mode == 2'h3;
	endsequence
	key_open_a: assert property (open_s |=> !protect_status)
		else $error("open key did not unlock");
	mode_hold_a: assert property (!(kw && k == SPG_KEY_MODE) |=> $stable(guard_mode))
		else $error("mode changed without key");
	mode_load_a: assert property (kw && k == SPG_KEY_MODE |=> guard_mode == $past(sfr_wdata[1:0]))
		else $error("mode not loaded");
	window_len_a: assert property (!protect_status && guard_mode != 2'h0 |-> cnt_q < 6'h20)
		else $error("unlock window too long");
	ctl_lock_a: assert property (!cw |=> $stable(ctl))
		else $error("guarded bits changed");
	ctl_write_a: assert property (cw |=> ctl == $past(sfr_wdata[6:0]))
		else $error("guarded write lost");
	page_manual_a: assert property (sfr_wr && sfr_addr == SPG_ADDR_PAGE && !sfr_wdata[7]
		|=> page_sel == $past(sfr_wdata[2:0]))
		else $error("manual page not taken");
	page_read_a: assert property (sfr_rd && sfr_addr == SPG_ADDR_PAGE
		|=> sfr_rdata == {5'h00, $past(page_sel)})
		else $error("page read wrong");
	key_read_a: assert property (sfr_rd && sfr_addr == SPG_ADDR_KEY
		|=> sfr_rdata == {5'h00, $past(protect_status), $past(guard_mode)})
		else $error("key read wrong");
endmodule // spg_properties
bind spg_top spg_properties spg_properties_inst (.mclk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd,
	.sfr_wdata, .sfr_rdata, .page_sel, .protect_status, .guard_mode, .pll_divider_factor,
	.watchdog_enable_bit, .power_down_ctrl, .slowdown_ctrl);

// ---- spg_core_model.sv ----
// Core side model issuing SFR writes and reads
`timescale 1ns/10ps
module spg_core_model
(
	// Clock
	input wire logic mclk,
	// SFR access port
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
		sfr_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		@(negedge mclk);
		d = sfr_rdata;
	endtask
endmodule // spg_core_model

// ---- spg_top_bench.sv ----
// Self-checking bench for page select and write guard
`timescale 1ns/10ps
module spg_top_bench
	import spg_pkg::*;
;
	localparam logic [7:0] PG = SPG_ADDR_PAGE;
	localparam logic [7:0] KY = SPG_ADDR_KEY;
	localparam logic [7:0] SC = SPG_ADDR_SYSCTL;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	wire [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	wire sfr_wr, sfr_rd, protect_status, watchdog_enable_bit, power_down_ctrl, slowdown_ctrl;
	wire [2:0] page_sel;
	wire [1:0] guard_mode;
	wire [3:0] pll_divider_factor;
	wire [7:0] ctl = {1'b0, slowdown_ctrl, power_down_ctrl, watchdog_enable_bit, pll_divider_factor};
	int n_mismatch = 0;
	int samples_checked = 0;
	always #12.5 mclk = ~mclk;
	spg_top spg_top_inst (.mclk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.page_sel, .protect_status, .guard_mode, .pll_divider_factor, .watchdog_enable_bit,
		.power_down_ctrl, .slowdown_ctrl);
	spg_core_model cpu (.mclk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.rd(a, d);
		chk(d, exp);
	endtask
	task automatic cc(input logic [7:0] exp);
		@(negedge mclk);
		chk(ctl, exp);
	endtask
	task automatic rst();
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
	endtask
	task automatic t_page();
		rc(PG, 8'h00);
		cpu.wr(PG, 8'h05);
		rc(PG, 8'h05);
		cpu.wr(PG, 8'h73);
		rc(PG, 8'h03);
		for (int i = 0; i < 4; i++)
			cpu.wr(PG, {4'h8 + i[3:0], 4'h4 + i[3:0]});
		rc(PG, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			cpu.wr(PG, {4'hC + i[3:0], 4'h1});
			rc(PG, 8'h03 + i[7:0]);
		end
		$display("page test done");
	endtask
	task automatic t_guard();
		rc(KY, 8'h07);
		cpu.wr(SC, 8'h7F);
		cc(8'h00);
		cpu.wr(KY, 8'hF8);
		rc(KY, 8'h07);
		cpu.wr(KY, 8'hA8);
		rc(KY, 8'h07);
		cpu.wr(KY, 8'h98);
		rc(KY, 8'h03);
		cpu.wr(SC, 8'h7F);
		cc(8'h7F);
		cpu.wr(KY, 8'hA8);
		rc(KY, 8'h07);
		cpu.wr(SC, 8'h00);
		cc(8'h7F);
		cpu.wr(KY, 8'h98);
		repeat (20) @(posedge mclk);
		cpu.wr(KY, 8'h98);
		repeat (20) @(posedge mclk);
		rc(KY, 8'h03);
		repeat (12) @(posedge mclk);
		rc(KY, 8'h07);
		$display("guard test done");
	endtask
	task automatic t_mode();
		cpu.wr(KY, 8'hC0);
		rc(KY, 8'h00);
		cpu.wr(SC, 8'h15);
		cc(8'h15);
		cpu.wr(KY, 8'hAB);
		rc(KY, 8'h00);
		rst();
		rc(PG, 8'h00);
		rc(KY, 8'h07);
		cc(8'h00);
		cpu.wr(KY, 8'hC1);
		rc(KY, 8'h05);
		cpu.wr(KY, 8'h9B);
		rc(KY, 8'h05);
		$display("mode test done");
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		rst();
		t_page();
		t_guard();
		t_mode();
		final_report();
	end
	initial
	begin
		repeat (2000) @(posedge mclk);
		n_mismatch++;
		final_report();
	end
endmodule // spg_top_bench
